//--- design/baud_gen.sv
// Preset reloading baud divider clocked by a 2.0 MHz phase enable.
// Assumes the preset is steady except between reloads.
`timescale 1ns/1ns
module baud_gen (
  input wire logic hclk,
  input wire logic hresetn,
  baud_if.gen bus
);
  logic [16:0] acc_r;
  logic [16:0] acc_nxt;
  logic [16:0] acc_sum;
  logic phi_en_r;
  logic phi_en_nxt;
  logic [11:0] count_r;
  logic [11:0] count_nxt;
  logic tick_r;
  logic tick_nxt;

  // Fractional divider gives an average 2.0 MHz enable
  always_comb begin
    acc_sum = acc_r + serial_cfg_pkg::PHI_KHZ;
    acc_nxt = acc_sum;
    phi_en_nxt = 1'b0;
    if (acc_sum >= serial_cfg_pkg::SYS_CLK_KHZ) begin
      acc_nxt = acc_sum - serial_cfg_pkg::SYS_CLK_KHZ;
      phi_en_nxt = 1'b1;
    end
  end

  // Overflow reloads the preset and emits one tick
  always_comb begin
    count_nxt = count_r;
    tick_nxt = 1'b0;
    if (phi_en_r) begin
      if (count_r >= serial_cfg_pkg::BAUD_TERMINAL) begin
        count_nxt = bus.preset;
        tick_nxt = 1'b1;
      end else begin
        count_nxt = count_r + 12'h001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= 17'h00000;
      phi_en_r <= 1'b0;
      // Start at terminal so the first enable loads the preset
      count_r <= serial_cfg_pkg::BAUD_TERMINAL;
      tick_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      phi_en_r <= phi_en_nxt;
      count_r <= count_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Sixteen-times rate tick to the transceiver
  assign bus.tick = tick_r;

  AST_RELOAD: assert property (@(posedge hclk) disable iff (!hresetn)
    tick_r |-> count_r == $past(bus.preset))
    else $error("Tick without preset reload");
  AST_TERMINAL: assert property (@(posedge hclk) disable iff (!hresetn)
    phi_en_r && count_r == serial_cfg_pkg::BAUD_TERMINAL |=> tick_r)
    else $error("Overflow did not tick");
endmodule

//--- design/baud_if.sv
// Carries the divider preset to the baud generator and its tick back.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ns
interface baud_if;
  logic [11:0] preset;
  logic tick;
  modport gen (input preset, output tick);
  modport user (output preset, input tick);
endinterface

//--- design/serial_cfg_pkg.sv
// Constants shared by the serial port configuration block and its divider.
// Assumes a 125 MHz bus clock and a 32-bit AHB-Lite register slave.
package serial_cfg_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h04;
  localparam logic [7:0] JUMP_OFS = 8'h08;
  localparam logic [7:0] PTOP_OFS = 8'h0C;
  localparam logic [7:0] PBOT_OFS = 8'h10;
  localparam logic [7:0] SMAP_OFS = 8'h14;
  localparam logic [7:0] STAT_OFS = 8'h18;
  localparam logic [7:0] CHA_OFS = 8'h1C;
  localparam logic [7:0] CHB_OFS = 8'h20;
  localparam logic [7:0] FMT_OFS = 8'h24;
  // Configuration register fields
  localparam int CFG_HARD_BIT = 0;
  localparam int CFG_PERIPH_BIT = 1;
  localparam int CFG_TWO_BIT = 2;
  localparam int CFG_LINE_LSB = 3;
  localparam logic [10:0] CFG_RESET = 11'h7F9;
  // Condition input jumper codes, three bits per input
  localparam logic [2:0] JMP_OPEN = 3'h0;
  localparam logic [2:0] JMP_GND = 3'h1;
  localparam logic [14:0] JUMP_RESET = 15'h0000;
  // Format field positions
  localparam int FMT_PAR_SUP = 0;
  localparam int FMT_STOP = 1;
  localparam int FMT_LEN_HI = 2;
  localparam int FMT_LEN_LO = 3;
  localparam int FMT_EVEN = 4;
  localparam logic [4:0] FMT_RESET = 5'h1F;
  // Line output source codes
  localparam logic [1:0] LINE_BIT0 = 2'h0;
  localparam logic [1:0] LINE_BIT1 = 2'h1;
  localparam logic [1:0] LINE_BIT3 = 2'h2;
  localparam logic [1:0] LINE_TXD = 2'h3;
  // Status source map, one nibble per status bit
  localparam logic [31:0] SMAP_RESET = 32'h9652_1043;
  localparam logic [3:0] STAT_SRC_COUNT = 4'hD;
  // Baud divider presets and terminal count
  localparam logic [11:0] PRESET_TOP_RESET = 12'hB85;
  localparam logic [11:0] PRESET_BOT_RESET = 12'hFE8;
  localparam logic [11:0] BAUD_TERMINAL = 12'hFF4;
  // System phase clock made from the bus clock
  localparam logic [16:0] SYS_CLK_KHZ = 17'h1E848;
  localparam logic [16:0] PHI_KHZ = 17'h007D0;
endpackage

//--- design/serial_port_config_baud_gen.sv
// Serial port control, format loading, baud preset and channel flags.
// Assumes an AHB-Lite master on a 125 MHz hclk and an external transceiver.
//
// Contract
// - Parity-suppress high: no parity bit sent, none checked.
// - Stop select low one stop bit, high two, 1.5 with five bits.
// - Two length selects choose 5, 6, 7 or 8 data bits.
// - Character length counts data bits; parity is framed in addition.
// - Even-parity select high gives even parity, low gives odd.
// - Condition inputs active high; undriven inputs read high.
// - Strobe tied to control writes: each write loads bits 4 to 7.
// - Hard-wired mode holds the strobe high; formats follow inputs.
// - Peripheral driver follows control bit 0 or bit 1 by option.
// - Line outputs pick bit 0, 1, 3 or serial data; never bit 2.
// - Baud divider reloads its preset on each overflow at 2.0 MHz.
// - Preset is a 12-bit value in three 4-bit groups.
// - Divider output runs at sixteen times the bit rate.
// - 110 baud uses modulus 1136, preset 2949.
// - 9600 baud uses modulus 13, preset 4072.
// - Differing preset bits follow control bits 2 and 3.
// - Active-low avail input sets flag; ack high; read clears.
// - Control bits 0 to 3 latched on write; 4 to 7 passed on.
// - Status word shows errors, ready, flags, line inputs on chosen bits.
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
module serial_port_config_baud_gen (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic tx_serial,
  input wire logic [3:0] line_in,
  input wire logic rx_parity_fault,
  input wire logic rx_framing_fault,
  input wire logic rx_overrun_fault,
  input wire logic rx_data_ready,
  input wire logic tx_holding_empty,
  input wire logic ext_latch_a,
  input wire logic ext_latch_b,
  input wire logic ext_avail_chan_a_n,
  input wire logic ext_avail_chan_b_n,
  input wire logic [7:0] chan_a_data,
  input wire logic [7:0] chan_b_data,
  output logic parity_suppress,
  output logic stop_length_select,
  output logic char_length_sel_hi,
  output logic char_length_sel_lo,
  output logic even_parity_select,
  output logic format_load_strobe,
  output logic baud16_tick,
  output logic periph_drive,
  output logic [3:0] line_out,
  output logic ack_chan_a,
  output logic ack_chan_b
);
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_ofs_r, wr_ofs_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [3:0] ctrl_hold_r, ctrl_hold_nxt;
  logic [3:0] ctrl_up_r, ctrl_up_nxt;
  logic [10:0] cfg_r, cfg_nxt;
  logic [14:0] jump_r, jump_nxt;
  logic [11:0] ptop_r, ptop_nxt;
  logic [11:0] pbot_r, pbot_nxt;
  logic [31:0] smap_r, smap_nxt;
  logic [4:0] fmt_r, fmt_nxt;
  logic strobe_r, strobe_nxt;
  logic flag_a_r, flag_a_nxt;
  logic flag_b_r, flag_b_nxt;
  logic periph_r, periph_nxt;
  logic [3:0] line_r, line_nxt;
  logic tick_r;
  logic ctrl_wr, clr_a, clr_b, addr_ok;
  logic [3:0] cond_up;
  logic [4:0] cond;
  logic [12:0] stat_src;
  logic [7:0] status;
  logic [11:0] preset_eff;

  baud_if baud ();

  baud_gen u_baud (
    .hclk(hclk),
    .hresetn(hresetn),
    .bus(baud)
  );

  // Level of one condition input as its jumper leaves it
  function automatic logic jmp_level(input logic [2:0] code,
                                     input logic [3:0] up);
    if (code[2])
      return up[code[1:0]];
    return code != serial_cfg_pkg::JMP_GND;
  endfunction

  // Line output source; control bit 2 has no code
  function automatic logic line_pick(input logic [1:0] code,
                                     input logic [3:0] hold,
                                     input logic txd);
    unique case (code)
      serial_cfg_pkg::LINE_BIT0: return hold[0];
      serial_cfg_pkg::LINE_BIT1: return hold[1];
      serial_cfg_pkg::LINE_BIT3: return hold[3];
      serial_cfg_pkg::LINE_TXD: return txd;
    endcase
  endfunction

  function automatic logic src_pick(input logic [3:0] code,
                                    input logic [12:0] src);
    if (code < serial_cfg_pkg::STAT_SRC_COUNT)
      return src[code];
    return 1'b0;
  endfunction

  // Preset bits that differ follow control bits 2 and 3
  always_comb begin
    if (cfg_r[serial_cfg_pkg::CFG_TWO_BIT])
      preset_eff = (ptop_r & pbot_r) |
                   (ptop_r & ~pbot_r & {12{ctrl_hold_r[2]}}) |
                   (~ptop_r & pbot_r & {12{ctrl_hold_r[3]}});
    else
      preset_eff = ptop_r;
  end
  assign baud.preset = preset_eff;

  assign stat_src = {line_in, ext_latch_b, ext_latch_a, flag_b_r, flag_a_r,
                     tx_holding_empty, rx_data_ready, rx_overrun_fault,
                     rx_framing_fault, rx_parity_fault};

  // Status bits placed by the source map
  always_comb begin
    for (int i = 0; i < 8; i++)
      status[i] = src_pick(smap_r[4*i +: 4], stat_src);
  end

  // Bus slave and register writes
  always_comb begin
    addr_ok = hsel && hready && htrans[1];
    wr_pend_nxt = addr_ok && hwrite;
    wr_ofs_nxt = haddr[7:0];
    ctrl_hold_nxt = ctrl_hold_r;
    ctrl_up_nxt = ctrl_up_r;
    cfg_nxt = cfg_r;
    jump_nxt = jump_r;
    ptop_nxt = ptop_r;
    pbot_nxt = pbot_r;
    smap_nxt = smap_r;
    ctrl_wr = 1'b0;
    if (wr_pend_r) begin
      unique case (wr_ofs_r)
        serial_cfg_pkg::CTRL_OFS: begin
          ctrl_wr = 1'b1;
          ctrl_hold_nxt = hwdata[3:0];
          ctrl_up_nxt = hwdata[7:4];
        end
        serial_cfg_pkg::CFG_OFS: cfg_nxt = hwdata[10:0];
        serial_cfg_pkg::JUMP_OFS: jump_nxt = hwdata[14:0];
        serial_cfg_pkg::PTOP_OFS: ptop_nxt = hwdata[11:0];
        serial_cfg_pkg::PBOT_OFS: pbot_nxt = hwdata[11:0];
        serial_cfg_pkg::SMAP_OFS: smap_nxt = hwdata;
        default: ;
      endcase
    end
  end

  // Reads are sampled in the address phase; register reads see a pending write, status and format reads do not
  always_comb begin
    hrdata_nxt = hrdata_r;
    clr_a = 1'b0;
    clr_b = 1'b0;
    if (addr_ok && !hwrite) begin
      hrdata_nxt = 32'h0000_0000;
      unique case (haddr[7:0])
        serial_cfg_pkg::CTRL_OFS: hrdata_nxt[7:0] = {ctrl_up_nxt,
                                                     ctrl_hold_nxt};
        serial_cfg_pkg::CFG_OFS: hrdata_nxt[10:0] = cfg_nxt;
        serial_cfg_pkg::JUMP_OFS: hrdata_nxt[14:0] = jump_nxt;
        serial_cfg_pkg::PTOP_OFS: hrdata_nxt[11:0] = ptop_nxt;
        serial_cfg_pkg::PBOT_OFS: hrdata_nxt[11:0] = pbot_nxt;
        serial_cfg_pkg::SMAP_OFS: hrdata_nxt = smap_nxt;
        serial_cfg_pkg::STAT_OFS: hrdata_nxt[7:0] = status;
        serial_cfg_pkg::CHA_OFS: begin
          hrdata_nxt[7:0] = chan_a_data;
          clr_a = 1'b1;
        end
        serial_cfg_pkg::CHB_OFS: begin
          hrdata_nxt[7:0] = chan_b_data;
          clr_b = 1'b1;
        end
        serial_cfg_pkg::FMT_OFS: hrdata_nxt[19:0] = {preset_eff, 3'h0,
                                                     fmt_r};
        default: ;
      endcase
    end
  end

  // Format loading: write strobe or held high when hard-wired
  always_comb begin
    strobe_nxt = cfg_r[serial_cfg_pkg::CFG_HARD_BIT] || ctrl_wr;
    cond_up = ctrl_wr ? hwdata[7:4] : ctrl_up_r;
    for (int i = 0; i < 5; i++)
      cond[i] = jmp_level(jump_r[3*i +: 3], cond_up);
    fmt_nxt = strobe_nxt ? cond : fmt_r;
  end

  // Channel flags; a set in the clearing cycle wins
  always_comb begin
    flag_a_nxt = !ext_avail_chan_a_n || (flag_a_r && !clr_a);
    flag_b_nxt = !ext_avail_chan_b_n || (flag_b_r && !clr_b);
  end

  // Output routing from the holding latch
  always_comb begin
    periph_nxt = cfg_r[serial_cfg_pkg::CFG_PERIPH_BIT] ? ctrl_hold_r[1]
                                                       : ctrl_hold_r[0];
    for (int i = 0; i < 4; i++)
      line_nxt[i] = line_pick(cfg_r[serial_cfg_pkg::CFG_LINE_LSB + 2*i +: 2],
                              ctrl_hold_r, tx_serial);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout <= 1'b0;
      ctrl_hold_r <= 4'h0;
      ctrl_up_r <= 4'hF;
      cfg_r <= serial_cfg_pkg::CFG_RESET;
      jump_r <= serial_cfg_pkg::JUMP_RESET;
      ptop_r <= serial_cfg_pkg::PRESET_TOP_RESET;
      pbot_r <= serial_cfg_pkg::PRESET_BOT_RESET;
      smap_r <= serial_cfg_pkg::SMAP_RESET;
      fmt_r <= serial_cfg_pkg::FMT_RESET;
      strobe_r <= 1'b0;
      flag_a_r <= 1'b0;
      flag_b_r <= 1'b0;
      periph_r <= 1'b0;
      line_r <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_ofs_r <= wr_ofs_nxt;
      hrdata_r <= hrdata_nxt;
      hreadyout <= 1'b1;
      ctrl_hold_r <= ctrl_hold_nxt;
      ctrl_up_r <= ctrl_up_nxt;
      cfg_r <= cfg_nxt;
      jump_r <= jump_nxt;
      ptop_r <= ptop_nxt;
      pbot_r <= pbot_nxt;
      smap_r <= smap_nxt;
      fmt_r <= fmt_nxt;
      strobe_r <= strobe_nxt;
      flag_a_r <= flag_a_nxt;
      flag_b_r <= flag_b_nxt;
      periph_r <= periph_nxt;
      line_r <= line_nxt;
      tick_r <= baud.tick;
    end
  end

  // Format fields drive the transceiver
  assign parity_suppress = fmt_r[serial_cfg_pkg::FMT_PAR_SUP];
  assign stop_length_select = fmt_r[serial_cfg_pkg::FMT_STOP];
  assign char_length_sel_hi = fmt_r[serial_cfg_pkg::FMT_LEN_HI];
  assign char_length_sel_lo = fmt_r[serial_cfg_pkg::FMT_LEN_LO];
  assign even_parity_select = fmt_r[serial_cfg_pkg::FMT_EVEN];
  assign format_load_strobe = strobe_r;
  assign baud16_tick = tick_r;
  assign periph_drive = periph_r;
  assign line_out = line_r;
  assign ack_chan_a = flag_a_r;
  assign ack_chan_b = flag_b_r;
  assign hrdata = hrdata_r;
  assign hresp = 1'b0;

  AST_HOLD_LATCH: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_ofs_r == serial_cfg_pkg::CTRL_OFS
    |=> ctrl_hold_r == $past(hwdata[3:0]))
    else $error("Control low nibble not latched");
  AST_FMT_STROBE: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_ofs_r == serial_cfg_pkg::CTRL_OFS && jump_r[11:0] == 12'hFAC
    |=> fmt_r[3:0] == $past(hwdata[7:4]))
    else $error("Control write did not load format");
  AST_FMT_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    !cfg_r[serial_cfg_pkg::CFG_HARD_BIT] && !ctrl_wr
    |=> $stable(fmt_r))
    else $error("Format changed without a load");
  AST_FMT_HARD: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r[serial_cfg_pkg::CFG_HARD_BIT] ##1 format_load_strobe
    |-> fmt_r == $past(cond))
    else $error("Hard-wired format not following inputs");
  AST_FLAG_SET: assert property (@(posedge hclk) disable iff (!hresetn)
    !ext_avail_chan_a_n |=> ack_chan_a ##0 flag_a_r)
    else $error("Avail input did not set flag");
  AST_FLAG_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
    flag_b_r && !clr_b |=> ack_chan_b)
    else $error("Flag dropped without a read");
  AST_PERIPH: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r[serial_cfg_pkg::CFG_PERIPH_BIT] ##1 $stable(ctrl_hold_r)
    |-> periph_drive == ctrl_hold_r[1])
    else $error("Peripheral driver on wrong bit");
  AST_LINE_TXD: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r[serial_cfg_pkg::CFG_LINE_LSB +: 2] == serial_cfg_pkg::LINE_TXD
    |=> line_out[0] == $past(tx_serial))
    else $error("Line output not carrying serial data");
  AST_TWO_RATE: assert property (@(posedge hclk) disable iff (!hresetn)
    cfg_r[serial_cfg_pkg::CFG_TWO_BIT] && ctrl_hold_r[3:2] == 2'b10
    |-> baud.preset == pbot_r)
    else $error("Second rate preset not selected");
  AST_STATUS: assert property (@(posedge hclk) disable iff (!hresetn)
    smap_r[3:0] == 4'h3 |-> status[0] == rx_data_ready)
    else $error("Status bit not mapped");
endmodule

//--- dv/periph_model.sv
// Parallel peripherals on channels A and B with active-low avail strobes.
// Assumes the bench raises one send bit for one hclk cycle per byte.
`timescale 1ns/1ns
module periph_model (
  input wire logic hclk,
  input wire logic [1:0] send,
  input wire logic [7:0] byte_in,
  input wire logic [1:0] ack,
  output logic [1:0] avail_n,
  output logic [7:0] data_a,
  output logic [7:0] data_b
);
  logic [7:0] held [2];
  logic [1:0] busy;
  logic [1:0] seen;

  initial begin
    avail_n = 2'h3;
    busy = 2'h0;
    seen = 2'h0;
    held[0] = 8'h00;
    held[1] = 8'h00;
  end

  always @(posedge hclk) begin
    for (int c = 0; c < 2; c++) begin
      // Strobe low for one cycle, pulled up otherwise
      avail_n[c] <= !send[c];
      if (send[c]) begin
        held[c] <= byte_in;
        busy[c] <= 1'b1;
        seen[c] <= 1'b0;
      end else if (ack[c]) begin
        seen[c] <= 1'b1;
      end else if (seen[c]) begin
        busy[c] <= 1'b0;
        seen[c] <= 1'b0;
      end
    end
  end

  // Data stable while flagged, scrambled once released
  assign data_a = busy[0] ? held[0] : ~held[0];
  assign data_b = busy[1] ? held[1] : ~held[1];
endmodule

//--- dv/serial_port_config_baud_gen_tb.sv
// Self-checking bench: AHB-Lite register accesses, routing, flags, baud.
// Assumes the design answers with zero wait states and OKAY responses.
`timescale 1ns/1ns
module serial_port_config_baud_gen_tb;
  logic hclk, hresetn, hsel, hwrite, hready, tx_serial, strobe;
  logic hreadyout, hresp, baud16_tick, periph_drive;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, send, avail_n, acks;
  logic [2:0] hsize;
  logic [12:0] src;
  logic [7:0] byte_in, data_a, data_b;
  logic [3:0] line_out;
  logic [4:0] fmt;
  int fails, checked, cyc, n;

  assign hready = hreadyout;

  serial_port_config_baud_gen i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tx_serial(tx_serial), .line_in(src[12:9]),
    .rx_parity_fault(src[0]), .rx_framing_fault(src[1]),
    .rx_overrun_fault(src[2]), .rx_data_ready(src[3]),
    .tx_holding_empty(src[4]), .ext_latch_a(src[7]),
    .ext_latch_b(src[8]), .ext_avail_chan_a_n(avail_n[0]),
    .ext_avail_chan_b_n(avail_n[1]), .chan_a_data(data_a),
    .chan_b_data(data_b), .parity_suppress(fmt[0]),
    .stop_length_select(fmt[1]), .char_length_sel_hi(fmt[2]),
    .char_length_sel_lo(fmt[3]), .even_parity_select(fmt[4]),
    .format_load_strobe(strobe), .baud16_tick(baud16_tick),
    .periph_drive(periph_drive), .line_out(line_out),
    .ack_chan_a(acks[0]), .ack_chan_b(acks[1]));

  periph_model i_periph (.hclk(hclk), .send(send), .byte_in(byte_in),
    .ack(acks), .avail_n(avail_n), .data_a(data_a), .data_b(data_b));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic print_verdict;
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      print_verdict;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One single transfer; entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(what, exp, rd);
  endtask

  // Control write in strobe mode, then format and routed outputs
  task automatic route(input logic [31:0] cfg, input logic [7:0] ctrl,
    input logic tx, input logic [4:0] ef, input logic [3:0] el,
    input logic ep);
    wr_reg(serial_cfg_pkg::CFG_OFS, cfg);
    tx_serial <= tx;
    wr_reg(serial_cfg_pkg::CTRL_OFS, {24'h000000, ctrl});
    @(posedge hclk);
    chk("load strobe", 32'h1, {31'h0, strobe});
    chk("format", {27'h0, ef}, {27'h0, fmt});
    @(posedge hclk);
    chk("load strobe end", 32'h0, {31'h0, strobe});
    chk("line_out", {28'h0, el}, {28'h0, line_out});
    chk("periph_drive", {31'h0, ep}, {31'h0, periph_drive});
  endtask

  task automatic tick_gap;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (baud16_tick !== 1'b1);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    tx_serial = 1'b0;
    src = 13'h0000;
    send = 2'h0;
    byte_in = 8'h00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("ctrl reset", serial_cfg_pkg::CTRL_OFS, 32'h000000F0);
    rd_chk("cfg reset", serial_cfg_pkg::CFG_OFS, 32'h000007F9);
    rd_chk("jump reset", serial_cfg_pkg::JUMP_OFS, 32'h00000000);
    rd_chk("ptop reset", serial_cfg_pkg::PTOP_OFS, 32'h00000B85);
    rd_chk("pbot reset", serial_cfg_pkg::PBOT_OFS, 32'h00000FE8);
    rd_chk("smap reset", serial_cfg_pkg::SMAP_OFS, 32'h96521043);
    rd_chk("fmt reset", serial_cfg_pkg::FMT_OFS, 32'h000B851F);
    wr_reg(serial_cfg_pkg::STAT_OFS, 32'h000000FF);
    rd_chk("status ro", serial_cfg_pkg::STAT_OFS, 32'h00000000);
    wr_reg(8'h28, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h28, 32'h00000000);
    chk("hard strobe", 32'h1, {31'h0, strobe});
    // Ground one condition input at a time, others left open
    for (int i = 0; i < 5; i++) begin
      wr_reg(serial_cfg_pkg::JUMP_OFS, 32'h1 << (3 * i));
      repeat (2) @(posedge hclk);
      chk("hard format", 32'h1F & ~(32'h1 << i), {27'h0, fmt});
    end
    // Inputs 0..3 from control bits 4..7, even select from bit 4
    wr_reg(serial_cfg_pkg::JUMP_OFS, 32'h00004FAC);
    route(32'h720, 8'hAB, 1'b0, 5'h0A, 4'h7, 1'b1);
    route(32'h720, 8'h54, 1'b1, 5'h15, 4'h8, 1'b0);
    route(32'h722, 8'h52, 1'b1, 5'h15, 4'hA, 1'b1);
    rd_chk("ctrl hold", serial_cfg_pkg::CTRL_OFS, 32'h00000052);
    // Each status source routed to all eight bits, two patterns
    for (int p = 0; p < 2; p++) begin
      src <= p ? 13'h058A : 13'h1A15;
      for (int k = 0; k < 14; k++) begin
        wr_reg(serial_cfg_pkg::SMAP_OFS, 32'(k) * 32'h11111111);
        @(posedge hclk);
        rd_chk("status", serial_cfg_pkg::STAT_OFS,
               (k < 13 && src[k % 13]) ? 32'hFF : 32'h0);
      end
    end
    src <= 13'h0000;
    wr_reg(serial_cfg_pkg::SMAP_OFS, serial_cfg_pkg::SMAP_RESET);
    for (int c = 0; c < 2; c++) begin
      byte_in <= 8'h5A ^ 8'(c);
      send[c] <= 1'b1;
      @(posedge hclk);
      send <= 2'h0;
      repeat (3) @(posedge hclk);
      chk("ack set", 32'h1, {31'h0, acks[c]});
      rd_chk("flag status", serial_cfg_pkg::STAT_OFS,
             c ? 32'h40 : 32'h20);
      rd_chk("chan data", c ? serial_cfg_pkg::CHB_OFS :
             serial_cfg_pkg::CHA_OFS, 32'h5A ^ 32'(c));
      chk("ack clear", 32'h0, {31'h0, acks[c]});
    end
    // Two-rate mode: bit3 high picks the bottom preset
    wr_reg(serial_cfg_pkg::CFG_OFS, 32'h00000724);
    wr_reg(serial_cfg_pkg::CTRL_OFS, 32'h00000058);
    @(posedge hclk);
    rd_chk("bottom preset", serial_cfg_pkg::FMT_OFS, 32'h000FE815);
    tick_gap;
    @(posedge hclk);
    chk("tick width", 32'h0, {31'h0, baud16_tick});
    tick_gap;
    // 13 enables at 2.0 MHz span 812.5 bus clocks, n + 1 of them
    chk("baud period", 32'h1, {31'h0, n >= 811 && n <= 812});
    wr_reg(serial_cfg_pkg::CTRL_OFS, 32'h00000054);
    @(posedge hclk);
    rd_chk("top preset", serial_cfg_pkg::FMT_OFS, 32'h000B8515);
    print_verdict;
  end
endmodule
